// ==== rtl/idm_data_mem.v ====
// internal data memory: banks, bit region, upper ram, stack, acc/aux regs
// assumes the core issues one access per cycle, synchronous to core_clk
`include "idm_regs.vh"
// Overview of operation
// - bytes 0x20..0x2F accessed as bytes or as 128 direct bits
// - upper 128 bytes reachable only by indirect addressing
// - direct above 0x7F hits sfr space; indirect hits upper ram
// - bytes 0x00..0x1F form four banks of eight registers
// - one active bank, chosen by status word bits 3 and 4
// - indirect access uses registers zero and one as index
// - bit address = (byte-0x20)*8 + bit position
// - bit operands give bit access, byte operands byte access
// - stack pointer marks last used; push writes sp+1 then increments
// - reset loads stack pointer with 0x07
// - stack may sit anywhere in 256 bytes, up to 256 deep
// - 1024-byte ram lies in external move space
// - 8-bit external move takes high byte from page control
// - with fifo access off, 16-bit address wraps every 0x0400
// - accumulator at 0xE0, bit addressable, rw, resets to zero
// - auxiliary register at 0xF0, bit addressable, rw, resets zero
module idm_data_mem (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	input wire clk_en,
	// access request from core
	input wire acc_req,
	input wire acc_wr,
	input wire [1:0] acc_mode,
	input wire [7:0] acc_addr,
	input wire [7:0] acc_wdata,
	input wire bit_wdata,
	input wire [2:0] reg_num,
	// stack operations
	input wire push_req,
	input wire pop_req,
	// external move
	input wire xmov_req,
	input wire xmov_wr,
	input wire xmov_use_data_pointer_pair,
	input wire xmov_use_r1,
	input wire [15:0] data_pointer_pair,
	input wire [7:0] xmov_wdata,
	input wire usb_fifo_access_enable,
	// answers
	output reg [7:0] rdata,
	output reg rbit,
	output reg rvalid,
	output reg [7:0] xmov_rdata_reg,
	output reg xmov_rvalid,
	output reg [7:0] primary_arith_register,
	output reg [7:0] aux_operand_register,
	output reg [7:0] stack_top_pointer,
	output reg [7:0] program_status_word
);
	// access modes
	localparam [1:0] MODE_DIRECT = 2'h0;
	localparam [1:0] MODE_INDIRECT = 2'h1;
	localparam [1:0] MODE_BIT = 2'h2;
	localparam [1:0] MODE_REG = 2'h3;

	// internal ram and decoded access target
	reg [7:0] iram [0:`IDM_IRAM_DEPTH-1];
	reg [7:0] xram_page_control;
	reg [7:0] ea;
	reg ea_sfr;
	reg [2:0] bpos;
	reg [7:0] rd_byte;
	reg [7:0] wr_byte;
	reg [7:0] idx;
	reg [15:0] xaddr;
	reg xmov_pend;
	wire [1:0] bank;
	wire [7:0] sp_inc;
	wire [7:0] xram_q;
	// next values of the registered outputs
	reg [7:0] acc_next;
	reg [7:0] aux_next;
	reg [7:0] sp_next;
	reg [7:0] psw_next;
	reg [7:0] page_next;
	reg [7:0] rdata_next;
	reg rbit_next;
	reg rvalid_next;
	wire sfr_wr;
	wire [7:0] bit_merge;

	assign bank = program_status_word[`IDM_PSW_BANK_HI:`IDM_PSW_BANK_LO];
	assign sp_inc = stack_top_pointer + 8'h01;
	assign sfr_wr = acc_req && acc_wr && ea_sfr;

	// bit write: one new bit merged into the byte just read
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_bit_merge
			assign bit_merge[gi] = (bpos == gi) ? bit_wdata : rd_byte[gi];
		end
	endgenerate

	// bank register address, shared by register and index decoding
	function [7:0] reg_addr;
		input [1:0] b;
		input [2:0] n;
		begin
			reg_addr = {3'h0, b, n};
		end
	endfunction

	// bit address to byte: lower half is ram, upper half is sfr bytes
	function [7:0] bit_byte;
		input [7:0] ba;
		begin
			if (ba[7])
				bit_byte = {ba[7:3], 3'h0};
			else
				bit_byte = `IDM_BIT_BASE + {4'h0, ba[6:3]};
		end
	endfunction

	// address decode
	always @*
	begin
		// index register of the active bank
		idx = iram[reg_addr(bank, {2'h0, reg_num[0]})];
		ea = acc_addr;
		ea_sfr = 1'b0;
		bpos = acc_addr[2:0];
		case (acc_mode)
			MODE_DIRECT:
			begin
				ea = acc_addr;
				ea_sfr = acc_addr > `IDM_LOWER_TOP;
			end
			MODE_INDIRECT:
			begin
				ea = idx;
				ea_sfr = 1'b0;
			end
			MODE_BIT:
			begin
				ea = bit_byte(acc_addr);
				ea_sfr = acc_addr[7];
			end
			MODE_REG:
			begin
				ea = reg_addr(bank, reg_num);
				ea_sfr = 1'b0;
			end
			default:
			begin
				ea = acc_addr;
				ea_sfr = 1'b0;
			end
		endcase
	end

	// byte read from ram or sfr
	always @*
	begin
		if (!ea_sfr)
			rd_byte = iram[ea];
		else
			case (ea)
				`IDM_SFR_ACC: rd_byte = primary_arith_register;
				`IDM_SFR_AUX: rd_byte = aux_operand_register;
				`IDM_SFR_SP: rd_byte = stack_top_pointer;
				`IDM_SFR_PSW: rd_byte = program_status_word;
				`IDM_SFR_PAGE: rd_byte = xram_page_control;
				// unmapped sfr addresses read as zero
				default: rd_byte = 8'h00;
			endcase
		wr_byte = acc_wdata;
		if (acc_mode == MODE_BIT)
			wr_byte = bit_merge;
	end

	// no reset on the ram: contents are undefined after power up
	// ram write port: data access, push; stack spans the whole 256 bytes
	always @(posedge core_clk)
	begin
		if (clk_en)
		begin
			if (push_req)
				iram[sp_inc] <= acc_wdata;
			else if (acc_req && acc_wr && !ea_sfr)
				iram[ea] <= wr_byte;
		end
	end

	// read answer; pop takes the read port ahead of a data read
	always @*
	begin
		rdata_next = rdata;
		rbit_next = rbit;
		rvalid_next = acc_req && !acc_wr;
		if (pop_req)
		begin
			rdata_next = iram[stack_top_pointer];
			rvalid_next = 1'b1;
		end
		else if (acc_req && !acc_wr)
		begin
			rdata_next = rd_byte;
			rbit_next = rd_byte[bpos];
		end
	end

	// sfr next values; a push or pop outranks a direct sp write
	always @*
	begin
		acc_next = primary_arith_register;
		aux_next = aux_operand_register;
		sp_next = stack_top_pointer;
		psw_next = program_status_word;
		page_next = xram_page_control;
		if (sfr_wr)
		begin
			case (ea)
				`IDM_SFR_ACC: acc_next = wr_byte;
				`IDM_SFR_AUX: aux_next = wr_byte;
				`IDM_SFR_SP: sp_next = wr_byte;
				`IDM_SFR_PSW: psw_next = wr_byte;
				`IDM_SFR_PAGE: page_next = wr_byte;
				// unmapped sfr addresses swallow the write
				default: page_next = xram_page_control;
			endcase
		end
		if (push_req)
			sp_next = sp_inc;
		else if (pop_req)
			sp_next = stack_top_pointer - 8'h01;
	end

	// sfr registers and stack pointer
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			primary_arith_register <= `IDM_ACC_RST;
			aux_operand_register <= `IDM_AUX_RST;
			stack_top_pointer <= `IDM_SP_RST;
			program_status_word <= `IDM_PSW_RST;
			xram_page_control <= `IDM_PAGE_RST;
			rdata <= 8'h00;
			rbit <= 1'b0;
			rvalid <= 1'b0;
		end
		else if (clk_en)
		begin
			// every flop here holds while clk_en is low
			rvalid <= rvalid_next;
			rdata <= rdata_next;
			rbit <= rbit_next;
			primary_arith_register <= acc_next;
			aux_operand_register <= aux_next;
			stack_top_pointer <= sp_next;
			program_status_word <= psw_next;
			xram_page_control <= page_next;
		end
	end

	// external move address; fifo window beyond ram is outside this block
	always @*
	begin
		if (xmov_use_data_pointer_pair)
			xaddr = data_pointer_pair;
		else
			xaddr = {xram_page_control, idx};
	end

	// upper 6 bits dropped: ram mirrors every 0x0400
	idm_xram u_xram (
		.core_clk(core_clk),
		.clk_en(clk_en),
		.addr(xaddr[`IDM_XRAM_AW-1:0]),
		.wr_en(xmov_req && xmov_wr && !usb_fifo_access_enable),
		.wdata(xmov_wdata),
		.rdata(xram_q)
	);

	// external read answer two cycles after the request
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xmov_pend <= 1'b0;
			xmov_rvalid <= 1'b0;
			xmov_rdata_reg <= 8'h00;
		end
		else if (clk_en)
		begin
			xmov_pend <= xmov_req && !xmov_wr;
			xmov_rvalid <= xmov_pend;
			if (xmov_pend)
				xmov_rdata_reg <= xram_q;
		end
	end
endmodule // idm_data_mem

// ==== rtl/idm_regs.vh ====
// address map and reset constants for the internal data memory block
// assumes inclusion by every design file of the block
`ifndef IDM_REGS_VH
`define IDM_REGS_VH
`define IDM_SFR_ACC 8'hE0
`define IDM_SFR_AUX 8'hF0
`define IDM_SFR_SP 8'h81
`define IDM_SFR_PSW 8'hD0
`define IDM_SFR_PAGE 8'hAA
`define IDM_ACC_RST 8'h00
`define IDM_AUX_RST 8'h00
`define IDM_SP_RST 8'h07
`define IDM_PSW_RST 8'h00
`define IDM_PAGE_RST 8'h00
`define IDM_PSW_BANK_LO 3
`define IDM_PSW_BANK_HI 4
`define IDM_LOWER_TOP 8'h7F
`define IDM_BIT_BASE 8'h20
`define IDM_XRAM_AW 10
`define IDM_XRAM_DEPTH 1024
`define IDM_IRAM_DEPTH 256
`endif

// ==== rtl/idm_xram.v ====
// 1024-byte on-chip ram seen through the external move space
// assumes the core offers one access per cycle with a write strobe
`include "idm_regs.vh"
module idm_xram (
	// clock and clock enable
	input wire core_clk,
	input wire clk_en,
	// access
	input wire [`IDM_XRAM_AW-1:0] addr,
	input wire wr_en,
	input wire [7:0] wdata,
	output reg [7:0] rdata
);
	reg [7:0] mem [0:`IDM_XRAM_DEPTH-1];
	// no reset: ram contents are undefined at power up
	always @(posedge core_clk)
	begin
		if (clk_en)
		begin
			if (wr_en)
				mem[addr] <= wdata;
			rdata <= mem[addr];
		end
	end
endmodule // idm_xram

// ==== verif/idm_data_mem_monitor.sv ====
// assertions on the data memory ports
// assumes checks pause while reset or a low clk_en holds the block
module idm_data_mem_monitor (
	input logic core_clk, rst_n, clk_en, acc_req, acc_wr, push_req, pop_req,
	input logic xmov_req, xmov_wr, rvalid, xmov_rvalid,
	input logic [1:0] acc_mode,
	input logic [7:0] acc_addr, acc_wdata, rdata, stack_top_pointer,
	input logic [7:0] primary_arith_register, aux_operand_register
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n || !clk_en);
	wire rd = acc_req && !acc_wr || pop_req;
	wire dw = acc_req && acc_wr && acc_mode == 2'h0;
	sp_reset_a: assert property ($rose(rst_n) |->
		stack_top_pointer == 8'h07) else $error("bad reset sp");
	push_step_a: assert property (push_req |=>
		stack_top_pointer == $past(stack_top_pointer) + 8'h01)
		else $error("bad push step");
	rd_valid_a: assert property (rd |=> rvalid)
		else $error("no read valid");
	no_valid_a: assert property (!rd |=> !rvalid)
		else $error("stray read valid");
	acc_read_a: assert property (rd && !pop_req && !acc_mode
		&& acc_addr == 8'hE0 |=> rdata == primary_arith_register)
		else $error("bad acc read");
	acc_write_a: assert property (dw && acc_addr == 8'hE0 |=>
		primary_arith_register == $past(acc_wdata)) else $error("acc wr");
	aux_write_a: assert property (dw && acc_addr == 8'hF0 |=>
		aux_operand_register == $past(acc_wdata)) else $error("aux wr");
	xmov_lat_a: assert property (xmov_req && !xmov_wr |->
		##2 xmov_rvalid) else $error("late ext read");
	cover property (push_req);
	cover property (pop_req);
	cover property (xmov_rvalid);
	cover property (rvalid && acc_mode == 2'h1);
endmodule // idm_data_mem_monitor
bind idm_data_mem idm_data_mem_monitor idm_data_mem_monitor_i (.*);

// ==== verif/idm_core_model.sv ====
// core side: issues one request per call
// assumes calls come one at a time after reset
module idm_core_model (
	input logic core_clk,
	output logic acc_req, acc_wr, bit_wdata, push_req, pop_req,
	output logic xmov_req, xmov_wr, xmov_use_data_pointer_pair, xmov_use_r1,
	output logic usb_fifo_access_enable,
	output logic [1:0] acc_mode,
	output logic [2:0] reg_num,
	output logic [7:0] acc_addr, acc_wdata, xmov_wdata,
	output logic [15:0] data_pointer_pair
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{acc_req, acc_wr, bit_wdata, push_req, pop_req, xmov_req} = '0;
		{xmov_wr, xmov_use_r1, usb_fifo_access_enable, acc_mode} = '0;
		{reg_num, acc_addr, acc_wdata, xmov_wdata, data_pointer_pair} = '0;
		xmov_use_data_pointer_pair = 1'b1;
	end
	// kind 0 access, 1 push, 2 external move, 3 pop; held one cycle
	// external move: m[0] page:index addressing, m[1] fifo access on
	task req(input [1:0] k, m, input w, input [2:0] n,
		input [7:0] a, d, input [15:0] p);
		@(posedge core_clk);
		{acc_req, push_req, xmov_req} <= {k == 2'h0, k == 2'h1, k == 2'h2};
		pop_req <= k == 2'h3;
		xmov_use_data_pointer_pair <= !(k == 2'h2 && m[0]);
		usb_fifo_access_enable <= k == 2'h2 && m[1];
		{acc_mode, acc_wr, xmov_wr, reg_num, acc_addr} <= {m, w, w, n, a};
		{acc_wdata, xmov_wdata, bit_wdata} <= {d, d, d[0]};
		data_pointer_pair <= p;
		@(posedge core_clk);
		{acc_req, push_req, xmov_req, pop_req} <= 4'h0;
	endtask
endmodule // idm_core_model

// ==== verif/internal_data_memory_map_bench.sv ====
// self-checking bench for the data memory block
// assumes core model drives requests; clk_en dropped once for a freeze
module internal_data_memory_map_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
	logic acc_req, acc_wr, bit_wdata, push_req, pop_req, xmov_req, xmov_wr;
	logic xmov_use_data_pointer_pair, xmov_use_r1, usb_fifo_access_enable;
	logic rbit, rvalid, xmov_rvalid;
	logic [1:0] acc_mode;
	logic [2:0] reg_num;
	logic [7:0] acc_addr, acc_wdata, xmov_wdata, rdata, xmov_rdata_reg, x;
	logic [7:0] primary_arith_register, aux_operand_register;
	logic [7:0] stack_top_pointer, program_status_word;
	logic [15:0] data_pointer_pair;
	logic [31:0] s = 32'h0d90_bbe6;
	int fails = 0, comparisons = 0, cycles = 0;
	idm_data_mem idm_data_mem_i (.*);
	idm_core_model idm_core_model_i (.*);
	initial forever #2 core_clk = ~core_clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	function automatic logic [7:0] bank_addr(input [1:0] b, input [2:0] n);
		return {3'h0, b, n};
	endfunction
	task chk(input logic [15:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task w(input [1:0] m, input [2:0] n, input [7:0] a, d);
		idm_core_model_i.req(2'h0, m, 1'b1, n, a, d, 16'h0000);
	endtask
	task r(input [1:0] m, input [2:0] n, input [7:0] a);
		idm_core_model_i.req(2'h0, m, 1'b0, n, a, 8'h00, 16'h0000);
		#1 x = rdata;
	endtask
	task report_and_stop;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ceiling well above the hundred or so cycles used
	always @(posedge core_clk)
		if (++cycles == 5000)
		begin
			fails++;
			report_and_stop;
		end
	initial
	begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		chk(stack_top_pointer, 8'h07);
		chk({primary_arith_register, aux_operand_register}, 0);
		s = xs(s);
		idm_core_model_i.req(2'h1, 0, 0, 0, 0, s[7:0], 0);
		r(0, 0, 8'h08);
		chk(x, s[7:0]);
		repeat (4)
		begin
			s = xs(s);
			w(0, 0, 8'hE0, s[7:0]);
			w(0, 0, 8'hF0, s[15:8]);
			r(0, 0, 8'hE0);
			chk(x, s[7:0]);
			chk(aux_operand_register, s[15:8]);
		end
		w(2, 0, 8'hE5, 8'h01);
		chk(primary_arith_register[5], 1'b1);
		for (int b = 0; b < 4; b++)
		begin
			s = xs(s);
			w(0, 0, 8'hD0, 8'(b << 3));
			w(3, s[10:8], 0, s[7:0]);
			r(0, 0, bank_addr(2'(b), s[10:8]));
			chk(x, s[7:0]);
		end
		w(0, 0, 8'h22, 8'h00);
		w(2, 0, 8'h13, 8'h01);
		r(0, 0, 8'h22);
		chk(x, 8'h08);
		r(2, 0, 8'h13);
		chk(rbit, 1'b1);
		chk(x, 8'h08);
		w(3, 1, 0, 8'h90);
		w(1, 1, 0, s[23:16]);
		r(1, 1, 0);
		chk(x, s[23:16]);
		r(0, 0, 8'h90);
		chk(x, 8'h00);
		// stack moved into upper ram, read back through index zero
		s = xs(s);
		w(3, 0, 0, 8'hC1);
		w(0, 0, 8'h81, 8'hC0);
		idm_core_model_i.req(2'h1, 0, 0, 0, 0, s[7:0], 0);
		#1 chk(stack_top_pointer, 8'hC1);
		r(1, 0, 0);
		chk(x, s[7:0]);
		r(0, 0, 8'hC1);
		chk(x, 8'h00);
		idm_core_model_i.req(2'h3, 0, 0, 0, 0, 0, 0);
		#1 chk(rdata, s[7:0]);
		chk(stack_top_pointer, 8'hC0);
		idm_core_model_i.req(2, 0, 1, 0, 0, s[7:0], 16'h0405);
		idm_core_model_i.req(2, 0, 0, 0, 0, 0, {s[31:26], 10'h005});
		@(posedge core_clk);
		#1 chk(xmov_rdata_reg, s[7:0]);
		// 8-bit external move: page register gives the high byte
		w(0, 0, 8'hAA, 8'h02);
		s = xs(s);
		idm_core_model_i.req(2, 0, 1, 0, 0, s[7:0], {s[31:26], 10'h290});
		idm_core_model_i.req(2, 1, 0, 1, 0, 0, 0);
		@(posedge core_clk);
		#1 chk(xmov_rdata_reg, s[7:0]);
		// fifo access on: the ram write is refused
		idm_core_model_i.req(2, 2, 1, 0, 0, ~s[7:0], 16'h0290);
		idm_core_model_i.req(2, 0, 0, 0, 0, 0, 16'h0290);
		@(posedge core_clk);
		#1 chk(xmov_rdata_reg, s[7:0]);
		// clock enable low: a write must not land
		w(0, 0, 8'hE0, 8'hA5);
		clk_en <= 1'b0;
		w(0, 0, 8'hE0, 8'h5A);
		clk_en <= 1'b1;
		#1 chk(primary_arith_register, 8'hA5);
		// second reset in mid-run
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		#1 chk(stack_top_pointer, 8'h07);
		chk(primary_arith_register, 8'h00);
		report_and_stop;
	end
endmodule // internal_data_memory_map_bench
